// file: ssarb_regs.svh
// Constants for the slave-side share arbiter and burst adapter.
// Assumes inclusion by the arbiter design module; definitions only.
`ifndef SSARB_REGS_SVH
`define SSARB_REGS_SVH

// ----------------------------------------------------------------------
// Default configuration
// ----------------------------------------------------------------------
`define SSARB_NUM_MASTERS 2
`define SSARB_ADDR_W 32
`define SSARB_DATA_W 32
`define SSARB_BCNT_W 8
`define SSARB_SHARE_W 8
`define SSARB_SLV_MAX_BURST 8
`define SSARB_IDLE_CYCLES 1

`endif

// file: ssarb_pkg.sv
// Types for the slave-side share arbiter and burst adapter.
// Assumes a single synchronous clock domain.
`default_nettype none
package ssarb_pkg;
   typedef enum logic [1:0] {
      SSARB_IDLE = 2'b00,
      SSARB_GAP = 2'b01,
      SSARB_XFER = 2'b10
   } ssarb_state_e;
endpackage : ssarb_pkg
`default_nettype wire

// file: ssarb_rr_pick.sv
// Round-robin picker: first requester at or after the pointer.
// Assumes request and pointer are settled within the cycle.
`timescale 1ns/1ns
`default_nettype none
module ssarb_rr_pick #(
   parameter int N = 2,
   parameter int IW = 1
) (
   // Inputs
   input wire logic [N-1:0] req_in,
   input wire logic [IW-1:0] ptr_in,
   // Outputs
   output logic any_out,
   output logic [IW-1:0] idx_out
);
   always_comb begin
      int k;
      k = 0;
      any_out = 1'b0;
      idx_out = '0;
      for (int i = N - 1; i >= 0; i--) begin
         k = (int'(ptr_in) + i) % N;
         if (req_in[k]) begin
            any_out = 1'b1;
            idx_out = IW'(k);
         end
      end
   end
endmodule : ssarb_rr_pick
`default_nettype wire

// file: ssarb_arbiter.sv
// Slave-side arbiter with fairness shares and a burst adapter.
// Assumes all masters and the slave share clk_in; masters hold their
// request, address, control and write data stable while stalled.
`timescale 1ns/1ns
`include "ssarb_regs.svh"
`default_nettype none

// Summary of operation
// R1: Examine every master's request and decide which master gets slave next.
// R2: Grant one master; hold all other requesters stalled until their turn.
// R3: Drive each master's wait-request; assert it for non-granted requesters.
// R4: Mux granted master's address, control, data to slave; return read data.
// R5: Each master has a configurable share count; one share buys one transfer.
// R6: Under contention a master does its shares back-to-back, then passes on.
// R7: A master dropping its request forfeits its shares; another is granted.
// R8: Every new grant reloads the master's full configured share count.
// R9: The slave is handed out among contenders in round-robin order.
// R10: Only currently requesting masters are considered; idle ones skipped.
// R11: Burst master states count at start; others blocked until burst ends.
// R12: For a burst master the burst length alone sets its hold time.
// R13: The burst adapter is a state machine resequencing address and control.
// R14: Long bursts split into maximum-length slave bursts plus a remainder.
// R15: A slave without bursts gets one single transfer per master beat.
// R16: Slave stays reserved until the whole original master burst completes.
// R17: One idle cycle is inserted before each burst issued to the slave.
// R18: Non-wrapping masters use single beats until aligned to burst boundary; the adapter splits bursts by length only.
// R19: Bursts starting on a master boundary never cross a slave boundary.
// R20: Only same-slave contention stalls; other slaves use their own arbiter.
// R21: Reset: no grant, shares cleared, round-robin pointer at master zero.
// R22: Grant changes only at a slave transfer boundary, never mid-stall.
module ssarb_arbiter
   import ssarb_pkg::*;
#(
   parameter int NUM_MASTERS = `SSARB_NUM_MASTERS,
   parameter int ADDR_W = `SSARB_ADDR_W,
   parameter int DATA_W = `SSARB_DATA_W,
   parameter int BCNT_W = `SSARB_BCNT_W,
   parameter int SHARE_W = `SSARB_SHARE_W,
   parameter int SLV_MAX_BURST = `SSARB_SLV_MAX_BURST,
   parameter bit SLV_BURST_EN = 1'b1,
   parameter bit SLV_WRAPPING_BURSTS = 1'b0
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Share configuration, one field per master
   input wire logic [NUM_MASTERS*SHARE_W-1:0] m_shares_in,
   // Master side requests
   input wire logic [NUM_MASTERS-1:0] m_read_in,
   input wire logic [NUM_MASTERS-1:0] m_write_in,
   input wire logic [NUM_MASTERS*ADDR_W-1:0] m_address_in,
   input wire logic [NUM_MASTERS*DATA_W-1:0] m_writedata_in,
   input wire logic [NUM_MASTERS*DATA_W/8-1:0] m_byteenable_in,
   input wire logic [NUM_MASTERS*BCNT_W-1:0] m_burstcount_in,
   // Master side answers
   output logic [NUM_MASTERS-1:0] m_waitrequest_out,
   output logic [NUM_MASTERS-1:0] m_readdatavalid_out,
   output logic [DATA_W-1:0] m_readdata_out,
   // Slave side requests
   output logic s_read_out,
   output logic s_write_out,
   output logic [ADDR_W-1:0] s_address_out,
   output logic [DATA_W-1:0] s_writedata_out,
   output logic [DATA_W/8-1:0] s_byteenable_out,
   output logic [BCNT_W-1:0] s_burstcount_out,
   // Slave side answers
   input wire logic s_waitrequest_in,
   input wire logic s_readdatavalid_in,
   input wire logic [DATA_W-1:0] s_readdata_in,
   // Status
   output logic busy_out,
   output logic [$clog2(NUM_MASTERS > 1 ? NUM_MASTERS : 2)-1:0] owner_out
);
   localparam int IW = $clog2(NUM_MASTERS > 1 ? NUM_MASTERS : 2);
   localparam int BW = DATA_W / 8;
   localparam int EFF_MAX = SLV_BURST_EN ? SLV_MAX_BURST : 1; // R15
   localparam logic [BCNT_W-1:0] MAX_B = BCNT_W'(EFF_MAX);

   // -------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------
   if (NUM_MASTERS < 1 || DATA_W % 8 != 0 || SHARE_W < 1) begin : g_bad_cfg
      $error("ssarb_arbiter: bad width or master count");
   end
   if (EFF_MAX < 1 || EFF_MAX >= (1 << BCNT_W)) begin : g_bad_burst
      $error("ssarb_arbiter: slave burst limit does not fit count");
   end

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   ssarb_state_e state_reg;
   logic [IW-1:0] owner_reg;
   logic [IW-1:0] ptr_reg;
   logic [SHARE_W-1:0] share_reg;
   logic is_read_reg;
   logic [BCNT_W-1:0] total_left_reg;   // Beats left in master burst
   logic [BCNT_W-1:0] seg_left_reg;     // Beats left in slave burst
   logic [BCNT_W-1:0] seg_len_reg;
   logic [ADDR_W-1:0] seg_addr_reg;
   logic [BCNT_W-1:0] rd_pend_reg;      // Read beats still to return

   // -------------------------------------------------------------------
   // Request view and round-robin choice
   // -------------------------------------------------------------------
   logic [NUM_MASTERS-1:0] req;
   logic pick_any;
   logic [IW-1:0] pick_idx;
   assign req = m_read_in | m_write_in; // R1 R10

   ssarb_rr_pick #(
      .N(NUM_MASTERS),
      .IW(IW)
   ) u_pick (
      .req_in(req),
      .ptr_in(ptr_reg),
      .any_out(pick_any),
      .idx_out(pick_idx)
   );

   // Fields of the picked and the owning master
   logic [BCNT_W-1:0] pick_bcnt;
   logic [SHARE_W-1:0] pick_share;
   logic [ADDR_W-1:0] own_addr;
   assign pick_bcnt = m_burstcount_in[pick_idx*BCNT_W +: BCNT_W];
   assign pick_share = m_shares_in[pick_idx*SHARE_W +: SHARE_W];
   assign own_addr = m_address_in[owner_reg*ADDR_W +: ADDR_W];

   // Master burst count of zero is taken as one beat
   function automatic logic [BCNT_W-1:0] norm_cnt(input logic [BCNT_W-1:0] c);
      norm_cnt = (c == '0) ? BCNT_W'(1) : c;
   endfunction : norm_cnt

   function automatic logic [BCNT_W-1:0] seg_of(input logic [BCNT_W-1:0] c);
      seg_of = (c > MAX_B) ? MAX_B : c; // R14
   endfunction : seg_of

   // -------------------------------------------------------------------
   // Beat accounting
   // -------------------------------------------------------------------
   logic beat_acc;      // Slave accepted one command beat
   logic last_beat;     // That beat ends the master burst
   logic seg_done;      // That beat ends the current slave burst
   logic own_req;
   assign own_req = req[owner_reg];
   assign beat_acc = (state_reg == SSARB_XFER) && !s_waitrequest_in &&
                     (is_read_reg ? (seg_left_reg == seg_len_reg)
                                  : own_req);
   assign last_beat = beat_acc &&
                      (is_read_reg ? (total_left_reg == seg_len_reg)
                                   : (total_left_reg == BCNT_W'(1)));
   assign seg_done = beat_acc &&
                     (is_read_reg || seg_left_reg == BCNT_W'(1));

   // Outstanding reads keep the slave reserved until the data returns
   logic rd_drained;
   assign rd_drained = (rd_pend_reg == '0);

   // Does the current owner keep the slave after this burst?
   logic keep_owner;
   assign keep_owner = (share_reg > SHARE_W'(1)) && own_req; // R6 R7

   // A new grant is taken only in IDLE, after reads have drained, so an
   // owner keeping shares re-enters through IDLE with the pointer at it.
   logic grant_now;
   assign grant_now = (state_reg == SSARB_IDLE) && pick_any &&
                      rd_drained;

   // -------------------------------------------------------------------
   // Burst adapter state machine
   // -------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin // R13
      if (!rst_n_in) begin
         state_reg <= SSARB_IDLE; // R21
      end else begin
         case (state_reg)
            SSARB_IDLE: begin
               if (grant_now)
                  state_reg <= SSARB_GAP; // R17
            end
            SSARB_GAP: begin
               state_reg <= SSARB_XFER;
            end
            SSARB_XFER: begin
               if (last_beat)
                  state_reg <= SSARB_IDLE; // R16 R22
               else if (seg_done)
                  state_reg <= SSARB_GAP; // R14 R17
            end
            default: begin
               state_reg <= SSARB_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Grant, round-robin pointer and shares
   // -------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         owner_reg <= '0;
         ptr_reg <= '0; // R21
         share_reg <= '0;
      end else begin
         // Owner idle in IDLE has dropped its request: shares forfeited
         if (state_reg == SSARB_IDLE && !own_req)
            share_reg <= '0; // R7
         if (grant_now) begin
            owner_reg <= pick_idx; // R2 R9
            // Fresh grant reloads; continuing owner keeps its remaining shares
            if (pick_idx != owner_reg || share_reg == '0)
               share_reg <= pick_share; // R5 R8
         end
         if (last_beat) begin
            if (keep_owner) begin
               share_reg <= share_reg - SHARE_W'(1); // R5 R6
               ptr_reg <= owner_reg;
            end else begin
               share_reg <= '0; // R7
               ptr_reg <= (owner_reg == IW'(NUM_MASTERS - 1)) ? '0
                          : owner_reg + IW'(1); // R9
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Burst bookkeeping
   // -------------------------------------------------------------------
   logic [BCNT_W-1:0] rest;
   assign rest = is_read_reg ? (total_left_reg - seg_len_reg)
                             : (total_left_reg - BCNT_W'(1));

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         is_read_reg <= 1'b0;
         total_left_reg <= '0;
         seg_left_reg <= '0;
         seg_len_reg <= '0;
         seg_addr_reg <= '0;
      end else begin
         if (grant_now) begin
            // Burst length alone sets the hold time
            is_read_reg <= m_read_in[pick_idx];
            total_left_reg <= norm_cnt(pick_bcnt); // R11 R12
            seg_len_reg <= seg_of(norm_cnt(pick_bcnt)); // R14 R15
            seg_left_reg <= seg_of(norm_cnt(pick_bcnt));
            seg_addr_reg <= m_address_in[pick_idx*ADDR_W +: ADDR_W];
         end else if (beat_acc) begin
            total_left_reg <= rest;
            if (seg_done) begin
               seg_len_reg <= seg_of(rest); // R14 R19
               seg_left_reg <= seg_of(rest);
               seg_addr_reg <= seg_addr_reg +
                  ADDR_W'(is_read_reg ? seg_len_reg : BCNT_W'(1)) *
                  ADDR_W'(BW);
            end else begin
               seg_left_reg <= seg_left_reg - BCNT_W'(1);
               seg_addr_reg <= seg_addr_reg + ADDR_W'(BW);
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_pend_reg <= '0;
      end else begin
         if (beat_acc && is_read_reg)
            rd_pend_reg <= rd_pend_reg + seg_len_reg -
                           BCNT_W'(s_readdatavalid_in);
         else if (s_readdatavalid_in && rd_pend_reg != '0)
            rd_pend_reg <= rd_pend_reg - BCNT_W'(1);
      end
   end

   // -------------------------------------------------------------------
   // Slave-side multiplexer
   // -------------------------------------------------------------------
   logic in_xfer;
   assign in_xfer = (state_reg == SSARB_XFER);

   always_comb begin // R4
      s_read_out = in_xfer && is_read_reg &&
                   (seg_left_reg == seg_len_reg);
      s_write_out = in_xfer && !is_read_reg && m_write_in[owner_reg];
      // Reads, and writes with SLV_WRAPPING_BURSTS, use the adapter's address; other writes use it on a slave burst's first beat, then the master's
      s_address_out = (is_read_reg || SLV_WRAPPING_BURSTS) ? seg_addr_reg
                      : (seg_left_reg == seg_len_reg ? seg_addr_reg
                                                     : own_addr);
      s_writedata_out = m_writedata_in[owner_reg*DATA_W +: DATA_W];
      s_byteenable_out = m_byteenable_in[owner_reg*BW +: BW];
      s_burstcount_out = seg_len_reg;
   end

   // -------------------------------------------------------------------
   // Master-side wait requests and read return
   // -------------------------------------------------------------------
   always_comb begin // R3
      m_waitrequest_out = req; // R2 R20
      if (in_xfer) begin
         if (is_read_reg)
            m_waitrequest_out[owner_reg] = !last_beat; // R11
         else
            m_waitrequest_out[owner_reg] = !beat_acc; // R22
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         m_readdata_out <= '0;
         m_readdatavalid_out <= '0;
      end else begin
         m_readdata_out <= s_readdata_in; // R4
         m_readdatavalid_out <= '0;
         if (s_readdatavalid_in && rd_pend_reg != '0)
            m_readdatavalid_out[owner_reg] <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Status
   // -------------------------------------------------------------------
   assign busy_out = (state_reg != SSARB_IDLE) || (rd_pend_reg != '0);
   assign owner_out = owner_reg;

endmodule : ssarb_arbiter
`default_nettype wire

// file: ssarb_arbiter_props.sv
// Checker of the share arbiter, bound into every arbiter instance.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ssarb_arbiter_props #(
   parameter int NUM_MASTERS = 2,
   parameter int ADDR_W = 32,
   parameter int DATA_W = 32,
   parameter int BCNT_W = 8,
   parameter int SLV_MAX_BURST = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Master side
   input wire logic [NUM_MASTERS-1:0] m_read_in,
   input wire logic [NUM_MASTERS-1:0] m_write_in,
   input wire logic [NUM_MASTERS*DATA_W-1:0] m_writedata_in,
   input wire logic [NUM_MASTERS-1:0] m_waitrequest_out,
   input wire logic [NUM_MASTERS-1:0] m_readdatavalid_out,
   input wire logic [DATA_W-1:0] m_readdata_out,
   // Slave side
   input wire logic s_read_out,
   input wire logic s_write_out,
   input wire logic [ADDR_W-1:0] s_address_out,
   input wire logic [DATA_W-1:0] s_writedata_out,
   input wire logic [BCNT_W-1:0] s_burstcount_out,
   input wire logic s_waitrequest_in,
   input wire logic s_readdatavalid_in,
   input wire logic [DATA_W-1:0] s_readdata_in,
   // Status
   input wire logic busy_out,
   input wire logic [$clog2(NUM_MASTERS > 1 ? NUM_MASTERS : 2)-1:0] owner_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [NUM_MASTERS-1:0] req;
   assign req = m_read_in | m_write_in;
   AST_ONE_GRANT: assert property ($onehot0(req & ~m_waitrequest_out))
      else $error("two masters released at once");
   AST_IDLE_STALLS: assert property (
      !busy_out |-> m_waitrequest_out == req)
      else $error("requester released while idle");
   AST_WDATA_MUX: assert property (
      s_write_out |->
      s_writedata_out == m_writedata_in[owner_out*DATA_W +: DATA_W])
      else $error("write data not from owner");
   AST_CMD_STANDS: assert property (
      s_write_out && s_waitrequest_in |=>
      s_write_out && $stable(s_address_out) && $stable(owner_out))
      else $error("stalled command changed");
   AST_GAP_FIRST: assert property (
      $rose(busy_out) |-> !s_write_out && !s_read_out)
      else $error("no idle cycle before burst");
   AST_SEG_LEN: assert property (
      (s_write_out || s_read_out) |->
      s_burstcount_out inside {[1:SLV_MAX_BURST]})
      else $error("slave burst length out of range");
   AST_RD_RETURN: assert property (
      s_readdatavalid_in |=>
      $onehot(m_readdatavalid_out) && m_readdatavalid_out[owner_out]
      && m_readdata_out == $past(s_readdata_in))
      else $error("read data not returned to owner");
   AST_OWNER_AT_IDLE: assert property (
      !$stable(owner_out) |-> !$past(busy_out))
      else $error("owner changed during a burst");
   AST_RESET_STATE: assert property (
      $rose(rst_n_in) |-> owner_out == '0 && !busy_out)
      else $error("state not cleared by reset");
endmodule : ssarb_arbiter_props
bind ssarb_arbiter ssarb_arbiter_props #(.NUM_MASTERS(NUM_MASTERS),
   .ADDR_W(ADDR_W), .DATA_W(DATA_W), .BCNT_W(BCNT_W),
   .SLV_MAX_BURST(SLV_MAX_BURST)) u_props (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .m_read_in(m_read_in), .m_write_in(m_write_in),
   .m_writedata_in(m_writedata_in), .m_waitrequest_out(m_waitrequest_out),
   .m_readdatavalid_out(m_readdatavalid_out),
   .m_readdata_out(m_readdata_out), .s_read_out(s_read_out),
   .s_write_out(s_write_out), .s_address_out(s_address_out),
   .s_writedata_out(s_writedata_out), .s_burstcount_out(s_burstcount_out),
   .s_waitrequest_in(s_waitrequest_in),
   .s_readdatavalid_in(s_readdatavalid_in), .s_readdata_in(s_readdata_in),
   .busy_out(busy_out), .owner_out(owner_out));
`default_nettype wire

// file: ssarb_slave_model.sv
// Slave model: stalls on request, returns address-derived read beats.
// Assumes the bench clock; read data is scrambled while not valid.
`timescale 1ns/1ns
`default_nettype none
module ssarb_slave_model (
   // Clock, reset and stall control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic stall_in,
   // Commands
   input wire logic read_in,
   input wire logic [31:0] address_in,
   input wire logic [7:0] burstcount_in,
   // Answers
   output logic waitrequest_out,
   output logic readdatavalid_out,
   output logic [31:0] readdata_out
);
   logic [31:0] beats[$];
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waitrequest_out <= 1'b1;
         readdatavalid_out <= 1'b0;
         readdata_out <= 32'h0000_0000;
         beats.delete();
      end else begin
         waitrequest_out <= stall_in;
         if (read_in && !waitrequest_out) begin
            for (int i = 0; i < int'(burstcount_in); i++) begin
               beats.push_back(address_in ^ i);
            end
         end
         readdatavalid_out <= (beats.size() > 0);
         readdata_out <= beats.size() > 0 ? beats.pop_front() : ~readdata_out;
      end
   end
endmodule : ssarb_slave_model
`default_nettype wire

// file: tb_slave_side_share_arbiter_burst_adapter.sv
// Bench: two masters driven here, the slave model on the far side.
// Assumes the arbiter's default build with slave bursts of eight.
`timescale 1ns/1ns
`default_nettype none
module tb_slave_side_share_arbiter_burst_adapter;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [15:0] m_shares_in = 16'h0203;
   logic [1:0] m_read_in = '0, m_write_in = '0;
   logic [63:0] m_address_in = '0, m_writedata_in = '0;
   logic [7:0] m_byteenable_in = 8'h3c;
   logic [15:0] m_burstcount_in = 16'h0101;
   logic [1:0] m_waitrequest_out, m_readdatavalid_out;
   logic [31:0] m_readdata_out, s_address_out, s_writedata_out, s_readdata_in;
   logic s_read_out, s_write_out, s_waitrequest_in, s_readdatavalid_in;
   logic busy_out, owner_out, stall = 1'b0, fresh = 1'b1;
   logic [3:0] s_byteenable_out;
   logic [7:0] s_burstcount_out;
   integer seed = 32'h714e_78d4;
   int miscompares = 0, num_checks = 0;
   logic [40:0] wq[$], rq[$];
   always #4 clk_in = ~clk_in;
   always @(posedge clk_in) stall <= (($random(seed) & 3) == 0);
   ssarb_arbiter dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .m_shares_in(m_shares_in), .m_read_in(m_read_in),
      .m_write_in(m_write_in), .m_address_in(m_address_in),
      .m_writedata_in(m_writedata_in), .m_byteenable_in(m_byteenable_in),
      .m_burstcount_in(m_burstcount_in), .m_waitrequest_out(m_waitrequest_out),
      .m_readdatavalid_out(m_readdatavalid_out),
      .m_readdata_out(m_readdata_out), .s_read_out(s_read_out),
      .s_write_out(s_write_out), .s_address_out(s_address_out),
      .s_writedata_out(s_writedata_out), .s_byteenable_out(s_byteenable_out),
      .s_burstcount_out(s_burstcount_out), .s_waitrequest_in(s_waitrequest_in),
      .s_readdatavalid_in(s_readdatavalid_in), .s_readdata_in(s_readdata_in),
      .busy_out(busy_out), .owner_out(owner_out));
   ssarb_slave_model slave (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .stall_in(stall), .read_in(s_read_out), .address_in(s_address_out),
      .burstcount_in(s_burstcount_out), .waitrequest_out(s_waitrequest_in),
      .readdatavalid_out(s_readdatavalid_in), .readdata_out(s_readdata_in));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Master request held until each beat is taken
   task automatic xfer(input int m, input bit rd, input int n,
                       input logic [7:0] bc, input logic [31:0] a, d);
      int k, g;
      logic acc;
      k = 0;
      g = 0;
      m_address_in[m*32 +: 32] <= a;
      m_burstcount_in[m*8 +: 8] <= bc;
      m_writedata_in[m*32 +: 32] <= d;
      if (rd) m_read_in[m] <= 1'b1;
      else m_write_in[m] <= 1'b1;
      while (k < n && g < 3000) begin
         @(negedge clk_in);
         acc = (m_waitrequest_out[m] === 1'b0);
         @(posedge clk_in);
         g++;
         if (acc) begin
            k++;
            m_writedata_in[m*32 +: 32] <= d + k;
         end
      end
      check("handshake", g < 3000, 1'b1);
      m_read_in[m] <= 1'b0;
      m_write_in[m] <= 1'b0;
   endtask : xfer
   task automatic drain();
      int g;
      g = 0;
      while (wq.size() + rq.size() != 0 && g < 500) begin
         @(posedge clk_in);
         g++;
      end
      check("pending results", wq.size() + rq.size(), 0);
   endtask : drain
   always @(posedge clk_in) begin : monitor
      logic [40:0] e;
      if (s_write_out && !s_waitrequest_in) begin
         e = wq.size() > 0 ? wq.pop_front() : 41'h1ff_ffff_ffff;
         check("write owner", owner_out, e[40]);
         check("write data", s_writedata_out, e[31:0]);
         check("byte lanes", s_byteenable_out, e[40] ? 4'h3 : 4'hc);
         if (fresh && e[39:32] != 0)
            check("length", s_burstcount_out, e[39:32]);
      end
      if (!s_write_out) fresh <= 1'b1;
      else if (!s_waitrequest_in) fresh <= 1'b0;
      if (|m_readdatavalid_out) begin
         e = rq.size() > 0 ? rq.pop_front() : 41'h1ff_ffff_ffff;
         check("read", {m_readdatavalid_out[1], m_readdata_out}, e[32:0]);
      end
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      tally_and_finish();
   end
   initial begin : main
      logic [31:0] d0, d1, a;
      int k0, k1;
      d0 = $random(seed);
      d1 = $random(seed);
      a = $random(seed) & 32'hffff_ffe0;
      k0 = 0;
      k1 = 0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      // Contention with three and two shares, both from the first edge
      for (int i = 0; i < 10; i++) begin
         if (i % 5 < 3) wq.push_back({1'b0, 8'h01, d0 + k0++});
         else wq.push_back({1'b1, 8'h01, d1 + k1++});
      end
      fork
         xfer(0, 1'b0, 6, 8'h01, 32'h0000_0100, d0);
         xfer(1, 1'b0, 4, 8'h01, 32'h0000_0200, d1);
      join
      drain();
      // Burst of fourteen at an aligned address outlives one share
      m_shares_in <= 16'h0201;
      for (int i = 0; i < 14; i++) begin
         wq.push_back({1'b0, i == 0 ? 8'h08 : i == 8 ? 8'h06 : 8'h00, d0 + i});
      end
      wq.push_back({1'b1, 8'h01, d1});
      wq.push_back({1'b1, 8'h01, d1 + 1});
      fork
         xfer(0, 1'b0, 14, 8'h0e, 32'h0000_0000, d0);
         begin
            @(posedge clk_in);
            xfer(1, 1'b0, 2, 8'h01, 32'h0000_0300, d1);
         end
      join
      drain();
      // Read burst of three, then a single read queued behind it
      for (int i = 0; i < 3; i++) rq.push_back({1'b1, a ^ i});
      rq.push_back({1'b0, a + 32'h0000_0040});
      fork
         xfer(1, 1'b1, 1, 8'h03, a, d1);
         begin
            @(posedge clk_in);
            xfer(0, 1'b1, 1, 8'h01, a + 32'h0000_0040, d0);
         end
      join
      drain();
      rst_n_in <= 1'b0;
      @(negedge clk_in);
      check("owner after reset", owner_out, 1'b0);
      check("busy after reset", busy_out, 1'b0);
      tally_and_finish();
   end
endmodule : tb_slave_side_share_arbiter_burst_adapter
`default_nettype wire
